// File: hw/pbs_pkg.sv
// Notes on behaviour
// - master puts 32-bit address when frame starts
// - lanes 39:32 low byte, 63:56 high byte
// - write data valid with irdy, read with trdy
// - word moves only when irdy and trdy
// - command on byte-enable groups during address
// - byte enables mark valid lanes in data
// - only master drives frame, held during transfer
// - frame low marks final data phase
// - claim driven only after own address decode
// - master samples target claim as input
// - grant is private line to this master
// - everything referenced to the one bus clock; both ends run on SYS_CLK_I and pass bus inputs through two sync stages
// - wide request asserted with frame
// - no wide ack with claim: fall back 32-bit
// - width fixed for whole transaction
package pbs_pkg;
   localparam logic [3:0] PBS_CMD_RESET   = 4'h0;
   localparam logic [7:0] PBS_BE_RESET    = 8'h00;
   // frame crosses two sync stages at the target and claim two at the master, so the window must cover both
   localparam logic [3:0] PBS_CLAIM_WAIT  = 4'h8;
   localparam int         PBS_DATA_W      = 32;

   typedef enum logic [1:0] {
      PBS_IDLE = 2'b00,
      PBS_ADDR = 2'b01,
      PBS_DATA = 2'b10,
      PBS_TURN = 2'b11
   } pbs_state_t;
endpackage

// File: hw/pbs_if.sv
`timescale 1ns/1ps
`default_nettype none
// active-high logical levels; each shared line carries an output enable per end
interface pbs_if;
   logic        clk;
   logic [31:0] m_ad;
   logic        m_ad_oe;
   logic [31:0] t_ad;
   logic        t_ad_oe;
   logic [3:0]  low_cmd_byte_enables;
   logic [3:0]  high_cmd_byte_enables;
   logic        cycle_frame;
   logic        initiator_ready;
   logic        wide_transfer_request;
   logic        m_oe;
   logic        target_claim;
   logic        target_ready;
   logic        wide_transfer_ack;
   logic        t_oe;
   logic        bus_grant;
   logic [31:0] upper_addr_data_lanes;
   assign upper_addr_data_lanes = m_ad_oe ? m_ad : (t_ad_oe ? t_ad : 32'h0000_0000);

   modport master (
      input  clk, t_ad, t_ad_oe, target_claim, target_ready, wide_transfer_ack, t_oe, bus_grant,
      output m_ad, m_ad_oe, low_cmd_byte_enables, high_cmd_byte_enables, cycle_frame,
             initiator_ready, wide_transfer_request, m_oe
   );
   modport target (
      input  clk, m_ad, m_ad_oe, low_cmd_byte_enables, high_cmd_byte_enables, cycle_frame,
             initiator_ready, wide_transfer_request, m_oe,
      output t_ad, t_ad_oe, target_claim, target_ready, wide_transfer_ack, t_oe, bus_grant
   );
endinterface
`default_nettype wire

// File: hw/pbs_master.sv
`timescale 1ns/1ps
`default_nettype none
// device end: bus master; one word per request, one data phase per transaction
module pbs_master
   import pbs_pkg::*;
(
   // clock and reset
   input  wire logic        SYS_CLK_I,
   input  wire logic        RESET_I,
   // user request
   input  wire logic        REQ_I,
   input  wire logic        WRITE_I,
   input  wire logic        WIDE_I,
   input  wire logic [3:0]  CMD_I,
   input  wire logic [31:0] ADDR_I,
   input  wire logic [31:0] WDATA_I,
   input  wire logic [3:0]  BE_I,
   output logic             BUSY_O,
   output logic             DONE_O,
   output logic             WIDE_O,
   output logic             NOCLAIM_O,
   output logic [31:0]      RDATA_O,
   // bus
   pbs_if.master            bus
);
   pbs_state_t  state_r;
   logic [3:0]  wait_r;
   logic        write_r;
   logic [31:0] wdata_r;
   logic [3:0]  be_r;
   logic [1:0]  gnt_sy_r;
   logic [1:0]  clm_sy_r;
   logic        clm_d_r;
   logic [1:0]  trdy_sy_r;
   logic [1:0]  ack_sy_r;
   logic [31:0] rd_sy0_r;
   logic [31:0] rd_sy1_r;
   logic        done_nxt;

   // ****************************************
   // input synchronisers
   // ****************************************
   always_ff @(posedge SYS_CLK_I) begin
      gnt_sy_r  <= {gnt_sy_r[0], bus.bus_grant};
      clm_sy_r  <= {clm_sy_r[0], bus.target_claim};
      clm_d_r   <= clm_sy_r[1];
      trdy_sy_r <= {trdy_sy_r[0], bus.target_ready};
      ack_sy_r  <= {ack_sy_r[0], bus.wide_transfer_ack};
      rd_sy0_r  <= bus.t_ad;
      rd_sy1_r  <= rd_sy0_r;
   end

   assign done_nxt = (state_r == PBS_DATA) && trdy_sy_r[1];

   // ****************************************
   // phase sequencer
   // ****************************************
   always_ff @(posedge SYS_CLK_I) begin
      if (RESET_I) begin
         state_r                   <= PBS_IDLE;
         wait_r                    <= 4'h0;
         bus.cycle_frame           <= 1'b0;
         bus.initiator_ready       <= 1'b0;
         bus.wide_transfer_request <= 1'b0;
         bus.m_oe                  <= 1'b0;
         bus.m_ad_oe               <= 1'b0;
         bus.m_ad                  <= 32'h0000_0000;
         bus.low_cmd_byte_enables  <= PBS_CMD_RESET;
         bus.high_cmd_byte_enables <= PBS_CMD_RESET;
         write_r                   <= 1'b0;
         wdata_r                   <= 32'h0000_0000;
         be_r                      <= 4'h0;
         BUSY_O                    <= 1'b0;
         DONE_O                    <= 1'b0;
         WIDE_O                    <= 1'b0;
         NOCLAIM_O                 <= 1'b0;
         RDATA_O                   <= 32'h0000_0000;
      end else begin
         DONE_O    <= 1'b0;
         NOCLAIM_O <= 1'b0;
         unique case (state_r)
            PBS_IDLE: begin
               // start only when granted and frame/irdy are idle
               if (REQ_I && gnt_sy_r[1] && !bus.cycle_frame && !bus.initiator_ready) begin
                  state_r                   <= PBS_ADDR;
                  BUSY_O                    <= 1'b1;
                  WIDE_O                    <= 1'b0;
                  bus.m_oe                  <= 1'b1;
                  bus.cycle_frame           <= 1'b1;
                  bus.wide_transfer_request <= WIDE_I;
                  bus.m_ad_oe               <= 1'b1;
                  bus.m_ad                  <= ADDR_I;
                  bus.low_cmd_byte_enables  <= CMD_I;
                  bus.high_cmd_byte_enables <= WIDE_I ? CMD_I : PBS_CMD_RESET;
                  write_r                   <= WRITE_I;
                  wdata_r                   <= WDATA_I;
                  be_r                      <= BE_I;
               end
            end
            PBS_ADDR: begin
               // single data phase, so frame drops with irdy rising
               state_r                   <= PBS_DATA;
               wait_r                    <= 4'h0;
               bus.cycle_frame           <= 1'b0;
               bus.wide_transfer_request <= 1'b0;
               bus.initiator_ready       <= 1'b1;
               bus.m_ad_oe               <= write_r;  // turn lanes over for reads
               bus.m_ad                  <= wdata_r;
               bus.low_cmd_byte_enables  <= be_r;
               bus.high_cmd_byte_enables <= be_r;
            end
            PBS_DATA: begin
               if (wait_r != 4'hf) begin
                  wait_r <= wait_r + 4'h1;
               end
               // the first cycle of claim decides the width for the whole transfer
               if (clm_sy_r[1] && !clm_d_r) begin
                  WIDE_O <= ack_sy_r[1];
               end
               if (done_nxt) begin
                  state_r   <= PBS_TURN;
                  DONE_O    <= 1'b1;
                  if (!write_r) begin
                     RDATA_O <= rd_sy1_r;
                  end
               end else if (!clm_sy_r[1] && wait_r >= PBS_CLAIM_WAIT) begin
                  state_r   <= PBS_TURN;
                  NOCLAIM_O <= 1'b1;
               end
            end
            PBS_TURN: begin
               state_r                   <= PBS_IDLE;
               BUSY_O                    <= 1'b0;
               bus.initiator_ready       <= 1'b0;
               bus.m_ad_oe               <= 1'b0;
               bus.m_oe                  <= 1'b0;
               bus.low_cmd_byte_enables  <= PBS_CMD_RESET;
               bus.high_cmd_byte_enables <= PBS_CMD_RESET;
            end
         endcase
      end
   end
endmodule
`default_nettype wire

// File: hw/pbs_target.sv
`timescale 1ns/1ps
`default_nettype none
// far end: arbiter plus one target that claims a programmable address window
module pbs_target
   import pbs_pkg::*;
(
   // clock and reset
   input  wire logic        SYS_CLK_I,
   input  wire logic        RESET_I,
   // arbiter and decode setup
   input  wire logic        GRANT_I,
   input  wire logic [31:0] BASE_I,
   input  wire logic [31:0] MASK_I,
   input  wire logic        WIDE_OK_I,
   input  wire logic [31:0] RDATA_I,
   // user side results
   output logic             WR_O,
   output logic [31:0]      WDATA_O,
   output logic [3:0]       BE_O,
   output logic [3:0]       CMD_O,
   output logic [31:0]      ADDR_O,
   // bus
   pbs_if.target            bus
);
   logic [1:0]  frm_sy_r;
   logic [1:0]  irdy_sy_r;
   logic [1:0]  req64_sy_r;
   logic [31:0] ad_sy0_r;
   logic [31:0] ad_sy1_r;
   logic [3:0]  cbe_sy0_r;
   logic [3:0]  cbe_sy1_r;
   logic        frm_d_r;
   logic        hit_r;
   logic        busy_r;
   logic        req64_r;

   always_ff @(posedge SYS_CLK_I) begin
      frm_sy_r   <= {frm_sy_r[0], bus.cycle_frame};
      irdy_sy_r  <= {irdy_sy_r[0], bus.initiator_ready};
      req64_sy_r <= {req64_sy_r[0], bus.wide_transfer_request};
      ad_sy0_r   <= bus.m_ad;
      ad_sy1_r   <= ad_sy0_r;
      cbe_sy0_r  <= bus.low_cmd_byte_enables;
      cbe_sy1_r  <= cbe_sy0_r;
   end

   always_ff @(posedge SYS_CLK_I) begin
      if (RESET_I) begin
         bus.bus_grant         <= 1'b0;
         bus.target_claim      <= 1'b0;
         bus.target_ready      <= 1'b0;
         bus.wide_transfer_ack <= 1'b0;
         bus.t_oe              <= 1'b0;
         bus.t_ad_oe           <= 1'b0;
         bus.t_ad              <= 32'h0000_0000;
         frm_d_r               <= 1'b0;
         hit_r                 <= 1'b0;
         busy_r                <= 1'b0;
         req64_r               <= 1'b0;
         WR_O                  <= 1'b0;
         WDATA_O               <= 32'h0000_0000;
         BE_O                  <= 4'h0;
         CMD_O                 <= PBS_CMD_RESET;
         ADDR_O                <= 32'h0000_0000;
      end else begin
         bus.bus_grant <= GRANT_I;
         frm_d_r       <= frm_sy_r[1];
         WR_O          <= 1'b0;
         if (frm_sy_r[1] && !frm_d_r && !busy_r) begin
            ADDR_O <= ad_sy1_r;
            CMD_O  <= cbe_sy1_r;
            busy_r <= 1'b1;
            // wide request only stands with frame, so keep it for the claim
            req64_r <= req64_sy_r[1];
            hit_r  <= ((ad_sy1_r ^ BASE_I) & MASK_I) == 32'h0000_0000;
         end else if (busy_r && hit_r && !bus.target_claim) begin
            bus.t_oe              <= 1'b1;
            bus.target_claim      <= 1'b1;
            bus.wide_transfer_ack <= WIDE_OK_I && req64_r;
            bus.target_ready      <= 1'b1;
            bus.t_ad_oe           <= !CMD_O[0];
            bus.t_ad              <= RDATA_I;
         end else if (busy_r && hit_r && irdy_sy_r[1] && bus.target_ready) begin
            WR_O                  <= CMD_O[0];
            WDATA_O               <= ad_sy1_r;
            BE_O                  <= cbe_sy1_r;
            hit_r                 <= 1'b0;
            bus.target_ready      <= 1'b0;
            bus.target_claim      <= 1'b0;
            bus.wide_transfer_ack <= 1'b0;
            bus.t_ad_oe           <= 1'b0;
            bus.t_oe              <= 1'b0;
         end else if (busy_r && !frm_sy_r[1] && !irdy_sy_r[1] && !bus.target_claim) begin
            busy_r <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// File: sim/pbs_chk_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ***
// wire checker
// ***
module pbs_chk (
   input wire logic clk,
   input wire logic RESET_I,
   input wire logic m_ad_oe,
   input wire logic t_ad_oe,
   input wire logic cycle_frame,
   input wire logic initiator_ready,
   input wire logic target_ready,
   input wire logic target_claim,
   input wire logic wide_transfer_request,
   input wire logic wide_transfer_ack,
   input wire logic bus_grant
);
   default clocking @(posedge clk); endclocking
   default disable iff (RESET_I);
   a_addr_on_frame: assert property ($rose(cycle_frame) |-> m_ad_oe)
      else $error("address not driven at frame start");
   a_frame_after_grant: assert property ($rose(cycle_frame) |->
      $past(bus_grant) && !$past(initiator_ready))
      else $error("frame without grant on idle bus");
   a_wide_with_frame: assert property ($rose(wide_transfer_request) |-> $rose(cycle_frame))
      else $error("wide request not with frame");
   a_frame_one_phase: assert property (cycle_frame |=> !cycle_frame && initiator_ready)
      else $error("final phase not entered");
   a_claim_in_txn: assert property ($rose(target_claim) |-> initiator_ready)
      else $error("claim outside access");
   a_ack_with_claim: assert property ($rose(wide_transfer_ack) |-> $rose(target_claim))
      else $error("wide ack apart from claim");
   a_read_data_on: assert property (target_ready |-> m_ad_oe || t_ad_oe)
      else $error("lanes undriven at target ready");
   a_xfer_ends: assert property (initiator_ready && target_ready |-> ##[1:6] !initiator_ready)
      else $error("initiator ready held after transfer");
   a_width_held: assert property (initiator_ready && $past(initiator_ready) && target_claim
      && $past(target_claim) |-> $stable(wide_transfer_ack))
      else $error("width changed in transaction");
endmodule
`default_nettype wire

// File: sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
   import pbs_pkg::*;
   localparam logic [31:0] IN_A  = 32'h1000_0040;
   localparam logic [31:0] OUT_A = 32'h2000_0000;
   logic clk, rst, req, wr, wide, busy, done, wide_o, noclaim, grant, wide_ok;
   logic t_wr, fr_q, q_cap, hit, miss;
   logic [3:0] cmd, be, t_be, t_cmd, c_cap, b_cap;
   logic [31:0] addr, wdata, rdata, trdata, t_wdata, t_addr, a_cap, d_cap;
   int num_errors, check_count, fr_cnt;
   pbs_if bus_if();
   assign bus_if.clk = clk;
   pbs_master pbs_master_i (.SYS_CLK_I(clk), .RESET_I(rst), .REQ_I(req), .WRITE_I(wr),
      .WIDE_I(wide), .CMD_I(cmd), .ADDR_I(addr), .WDATA_I(wdata), .BE_I(be), .BUSY_O(busy),
      .DONE_O(done), .WIDE_O(wide_o), .NOCLAIM_O(noclaim), .RDATA_O(rdata), .bus(bus_if));
   pbs_target pbs_target_i (.SYS_CLK_I(clk), .RESET_I(rst), .GRANT_I(grant),
      .BASE_I(32'h1000_0000), .MASK_I(32'hffff_0000), .WIDE_OK_I(wide_ok), .RDATA_I(trdata),
      .WR_O(t_wr), .WDATA_O(t_wdata), .BE_O(t_be), .CMD_O(t_cmd), .ADDR_O(t_addr), .bus(bus_if));
   pbs_chk pbs_chk_i (.clk(clk), .RESET_I(rst), .m_ad_oe(bus_if.m_ad_oe),
      .t_ad_oe(bus_if.t_ad_oe), .cycle_frame(bus_if.cycle_frame),
      .initiator_ready(bus_if.initiator_ready), .target_ready(bus_if.target_ready),
      .target_claim(bus_if.target_claim), .wide_transfer_request(bus_if.wide_transfer_request),
      .wide_transfer_ack(bus_if.wide_transfer_ack), .bus_grant(bus_if.bus_grant));
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // ***
   // wire capture at frame start and at each completed word
   // ***
   always @(posedge clk) begin
      if (bus_if.cycle_frame && !fr_q) begin
         a_cap <= bus_if.upper_addr_data_lanes;
         c_cap <= bus_if.low_cmd_byte_enables;
         q_cap <= bus_if.wide_transfer_request;
         fr_cnt <= fr_cnt + 1;
      end
      if (bus_if.initiator_ready && bus_if.target_ready) begin
         d_cap <= bus_if.upper_addr_data_lanes;
         b_cap <= bus_if.low_cmd_byte_enables;
      end
      fr_q <= bus_if.cycle_frame;
   end
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e) begin
         num_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic run(input logic w, input logic wd, input logic [31:0] a);
      int n;
      n = 0;
      @(negedge clk);
      wr = w;
      wide = wd;
      addr = a;
      cmd = w ? 4'h7 : 4'h6;
      req = 1'b1;
      while (busy !== 1'b1 && n < 60) begin
         @(negedge clk);
         n++;
      end
      req = 1'b0;
      hit = 1'b0;
      miss = 1'b0;
      while (busy === 1'b1 && n < 60) begin
         @(negedge clk);
         n++;
         if (done === 1'b1) hit = 1'b1;
         if (noclaim === 1'b1) miss = 1'b1;
      end
      if (n >= 60) chk(32'h0, 32'h1);
   endtask
   // ***
   // scenarios
   // ***
   task automatic t_write();
      wdata = 32'ha1b2_c3d4;
      be = 4'h5;
      run(1'b1, 1'b0, IN_A);
      chk(a_cap, IN_A);
      chk(c_cap, 32'h7);
      chk(d_cap[7:0], 32'hd4);
      chk(b_cap, 32'h5);
      chk(t_wdata, wdata);
      chk(hit, 32'h1);
   endtask
   task automatic t_read();
      trdata = 32'h5566_7788;
      run(1'b0, 1'b0, IN_A);
      chk(c_cap, 32'h6);
      chk(d_cap, trdata);
      chk(rdata, trdata);
   endtask
   task automatic t_wide();
      for (int k = 0; k < 2; k++) begin
         wide_ok = k[0];
         run(1'b1, 1'b1, IN_A);
         chk(q_cap, 32'h1);
         chk(wide_o, k);
      end
   endtask
   task automatic t_noclaim();
      run(1'b1, 1'b0, OUT_A);
      chk(miss, 32'h1);
      chk(hit, 32'h0);
   endtask
   task automatic t_grant();
      int f;
      grant = 1'b0;
      repeat (4) @(negedge clk);
      f = fr_cnt;
      req = 1'b1;
      repeat (12) @(negedge clk);
      chk(fr_cnt, f);
      req = 1'b0;
      grant = 1'b1;
      run(1'b0, 1'b0, IN_A);
      chk(hit, 32'h1);
   endtask
   task automatic tally_and_finish();
      $display("checks=%0d errors=%0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      rst = 1'b1;
      req = 1'b0;
      wr = 1'b0;
      wide = 1'b0;
      wide_ok = 1'b0;
      fr_q = 1'b0;
      fr_cnt = 0;
      cmd = 4'h0;
      be = 4'hf;
      addr = 32'h0;
      wdata = 32'h0;
      trdata = 32'h0;
      grant = 1'b1;
      repeat (16) @(posedge clk);
      @(negedge clk);
      rst = 1'b0;
      t_write();
      t_read();
      t_wide();
      t_noclaim();
      t_grant();
      tally_and_finish();
   end
   initial begin
      repeat (3000) @(posedge clk);
      num_errors++;
      tally_and_finish();
   end
endmodule
`default_nettype wire
